// ---- hw/psi_consts.svh ----
/*
 * Constants of the physical sensor information parameter block:
 * parameter numbers, lengths, byte offsets, flag fields and input ids.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef PSI_CONSTS_SVH
`define PSI_CONSTS_SVH

// ----------------------------------------------------------------
// parameter numbers and lengths
// ----------------------------------------------------------------
`define PSI_PID_PRESENT 16'h0120
`define PSI_PID_INFO_FIRST 16'h0121
`define PSI_PID_INFO_LAST 16'h0160
`define PSI_LEN_PRESENT 16'h0008
`define PSI_LEN_INFO 16'h0014
`define PSI_LEN_WRITE 16'h0008
`define PSI_LEN_NONE 16'h0000

// ----------------------------------------------------------------
// byte offsets within a response
// ----------------------------------------------------------------
`define PSI_HDR_BYTES 5'h04
`define PSI_OFF_LEN 5'h02
`define PSI_OFF_ID 5'h04
`define PSI_OFF_STORE0 5'h05
`define PSI_OFF_FLAGS 5'h0a
`define PSI_OFF_ADDR 5'h0b
`define PSI_OFF_MAT0 5'h12
`define PSI_OFF_RSVD 5'h17
`define PSI_STORE_BYTES 18
`define PSI_MAT_BYTES 5

// ----------------------------------------------------------------
// flags byte fields and codes
// ----------------------------------------------------------------
`define PSI_FLG_IRQ 0
`define PSI_FLG_MST_LO 1
`define PSI_FLG_MST_HI 4
`define PSI_FLG_PWR_LO 5
`define PSI_FLG_PWR_HI 7
`define PSI_MST_TWOWIRE_A 4'h2
`define PSI_MST_TWOWIRE_B 4'h4
`define PSI_ADDR_TOP 7

// ----------------------------------------------------------------
// input identifiers (bit positions in the presence bitmap)
// ----------------------------------------------------------------
`define PSI_SID_ACCEL 6'h01
`define PSI_SID_GYRO 6'h03
`define PSI_SID_MAG 6'h05
`define PSI_SID_GYRO_TEMP 6'h07
`define PSI_SID_ANY_MOTION 6'h09
`define PSI_SID_PRESSURE 6'h0b
`define PSI_SID_POSITION 6'h0d
`define PSI_SID_HUMIDITY 6'h0f
`define PSI_SID_TEMP 6'h11
`define PSI_SID_GAS 6'h13
`define PSI_SID_HW_STEP_CNT 6'h20
`define PSI_SID_HW_STEP_DET 6'h21
`define PSI_SID_HW_SIG_MOTION 6'h22
`define PSI_SID_HW_ANY_MOTION 6'h23
`define PSI_SID_CAMERA 6'h24
`define PSI_SID_GPS 6'h30
`define PSI_SID_LIGHT 6'h31
`define PSI_SID_PROXIMITY 6'h32

`endif

// ---- hw/psi_pkg.sv ----
/*
 * Types of the physical sensor information parameter block.
 * Assumes psi_consts.svh carries the numeric constants.
 */
package psi_pkg;

   typedef logic [7:0] psi_byte_t;

   typedef enum logic [0:0] {
      PSI_IDLE = 1'b0,
      PSI_SEND = 1'b1
   } psi_fsm_t;

endpackage

// ---- hw/psi_params.sv ----
/*
 * Physical sensor presence bitmap and per-sensor descriptors, streamed
 * byte by byte as parameter responses, plus runtime orientation writes
 * and a raw-to-east-north-up axis remap.
 * Assumes all inputs come from logic on clk_sys; descriptor bytes are
 * loaded by local firmware through the cfg port.
 */
`timescale 1ns/1ps
`include "psi_consts.svh"

// Behaviour
// - presence is 64-bit bitmap, bit per identifier
// - presence response: id 0x0120, length 8, bitmap
// - byte k holds ids 8k..8k+7, LSB lowest
// - fixed identifiers per sensor kind
// - 0x0121..0x0160 select descriptors of ids 0..63
// - absent sensor descriptor bytes all zero
// - length 20; id byte is parameter minus 0x0121
// - driver id, revision, current at 0x05..0x07
// - dynamic range at 0x08..0x09
// - flags bits 1..4 give master bus
// - flags bits 5..7 give power mode
// - address byte, top bit clear on two-wire
// - byte 0x0C names data-ready pin
// - bytes 0x0D..0x10 hold float sample rate
// - byte 0x11 holds axis count
// - nine signed nibbles packed in 0x12..0x16
// - raw row vector times matrix gives frame
// - host writes length 8 matrix; device applies
module psi_params #(
   parameter int NUM_SENSORS = 64,
   parameter int RAW_W = 16
) (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic [NUM_SENSORS-1:0] sensor_present, // presence by id
   input wire logic cfg_we, // descriptor byte load
   input wire logic [$clog2(NUM_SENSORS)-1:0] cfg_sid, // load sensor id
   input wire logic [4:0] cfg_off, // load byte offset
   input wire psi_pkg::psi_byte_t cfg_byte, // load data
   input wire logic rd_start, // read request
   input wire logic [15:0] rd_pid, // read parameter number
   output logic rd_ready, // read request may be taken
   output logic out_valid, // response byte valid
   output psi_pkg::psi_byte_t out_byte, // response byte
   output logic out_last, // final response byte
   input wire logic wr_start, // orientation write request
   input wire logic [15:0] wr_pid, // write parameter number
   input wire logic [15:0] wr_len, // write length field
   input wire logic [39:0] wr_matrix, // packed matrix, byte 0x04 low
   output logic wr_done, // write applied
   output logic wr_err, // write ignored
   input wire logic [$clog2(NUM_SENSORS)-1:0] remap_sid, // remap sensor
   input wire logic signed [RAW_W-1:0] raw_x, // raw x
   input wire logic signed [RAW_W-1:0] raw_y, // raw y
   input wire logic signed [RAW_W-1:0] raw_z, // raw z
   output logic signed [RAW_W+4:0] enu_x, // east
   output logic signed [RAW_W+4:0] enu_y, // north
   output logic signed [RAW_W+4:0] enu_z // up
);
   import psi_pkg::*;

   localparam int SIDW = $clog2(NUM_SENSORS);
   localparam int SB = `PSI_STORE_BYTES;
   localparam int OW = RAW_W + 5;

   typedef struct packed {
      logic [NUM_SENSORS-1:0][SB-1:0][7:0] mem;
      psi_fsm_t fsm;
      logic [15:0] pid;
      logic [4:0] idx;
      logic [4:0] last;
      logic [4:0] o_idx;
      logic [NUM_SENSORS-1:0] snap;
      logic [7:0] obyte;
      logic ovalid;
      logic olast;
      logic wdone;
      logic werr;
      logic signed [OW-1:0] ex;
      logic signed [OW-1:0] ey;
      logic signed [OW-1:0] ez;
   } psi_state_t;

   psi_state_t st_reg;
   psi_state_t st_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic is_info(input logic [15:0] p);
      return (p >= `PSI_PID_INFO_FIRST) && (p <= `PSI_PID_INFO_LAST);
   endfunction

   function automatic logic [15:0] resp_len(input logic [15:0] p);
      if (p == `PSI_PID_PRESENT)
         return `PSI_LEN_PRESENT;
      else if (is_info(p))
         return `PSI_LEN_INFO;
      else
         return `PSI_LEN_NONE;
   endfunction

   function automatic logic [SIDW-1:0] sid_of(input logic [15:0] p);
      return SIDW'(p - `PSI_PID_INFO_FIRST);
   endfunction

   function automatic logic signed [3:0] coef(input logic [39:0] m, input int k);
      return m[4*k +: 4];
   endfunction

   // one output axis: column c of the coefficient matrix
   function automatic logic signed [OW-1:0] column(input logic signed [RAW_W-1:0] x,
         input logic signed [RAW_W-1:0] y, input logic signed [RAW_W-1:0] z,
         input logic [39:0] m, input int c);
      logic signed [OW-1:0] s;
      s = OW'(x) * OW'(coef(m, c));
      s = s + OW'(y) * OW'(coef(m, c + 3));
      s = s + OW'(z) * OW'(coef(m, c + 6));
      return s;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic [SIDW-1:0] cur_sid;
   logic cur_pres;
   logic [SB-1:0][7:0] desc;
   logic [15:0] hdr16;
   logic [7:0] rbyte;
   logic [SIDW-1:0] wr_sid;
   logic wr_ok;
   logic [39:0] remap_mat;

   always_comb
   begin
      st_next = st_reg;
      st_next.ovalid = 1'b0;
      st_next.olast = 1'b0;
      st_next.wdone = 1'b0;
      st_next.werr = 1'b0;
      cur_sid = sid_of(st_reg.pid);
      cur_pres = st_reg.snap[cur_sid];
      desc = st_reg.mem[cur_sid];
      hdr16 = (st_reg.idx < `PSI_OFF_LEN) ? st_reg.pid : resp_len(st_reg.pid);
      rbyte = 8'h00;

      // response byte at st_reg.idx, all multi-byte fields low byte first
      if (st_reg.idx < `PSI_HDR_BYTES)
         rbyte = st_reg.idx[0] ? hdr16[15:8] : hdr16[7:0];
      else if (st_reg.pid == `PSI_PID_PRESENT)
         rbyte = st_reg.snap[8*(st_reg.idx - `PSI_HDR_BYTES) +: 8];
      else if (is_info(st_reg.pid) && cur_pres)
      begin
         if (st_reg.idx == `PSI_OFF_ID)
            rbyte = 8'(cur_sid);
         else if (st_reg.idx < `PSI_OFF_RSVD)
         begin
            // driver, current, range, flags, addr, pin, rate, axes, matrix
            rbyte = desc[5'(st_reg.idx - `PSI_OFF_STORE0)];
            if (st_reg.idx == `PSI_OFF_ADDR &&
                  (desc[`PSI_OFF_FLAGS - `PSI_OFF_STORE0][`PSI_FLG_MST_HI:`PSI_FLG_MST_LO] == `PSI_MST_TWOWIRE_A ||
                   desc[`PSI_OFF_FLAGS - `PSI_OFF_STORE0][`PSI_FLG_MST_HI:`PSI_FLG_MST_LO] == `PSI_MST_TWOWIRE_B))
               rbyte[`PSI_ADDR_TOP] = 1'b0;
         end
         else
            rbyte = 8'h00;
      end

      unique case (st_reg.fsm)
         PSI_IDLE:
         begin
            if (rd_start)
            begin
               st_next.pid = rd_pid;
               st_next.idx = 5'h00;
               st_next.last = 5'(`PSI_HDR_BYTES + resp_len(rd_pid) - 16'h0001);
               st_next.snap = sensor_present;
               st_next.fsm = PSI_SEND;
            end
         end
         PSI_SEND:
         begin
            st_next.obyte = rbyte;
            st_next.ovalid = 1'b1;
            st_next.o_idx = st_reg.idx;
            st_next.olast = (st_reg.idx == st_reg.last);
            st_next.idx = st_reg.idx + 5'h01;
            if (st_reg.idx == st_reg.last)
               st_next.fsm = PSI_IDLE;
         end
      endcase

      // firmware descriptor load
      if (cfg_we && cfg_off >= `PSI_OFF_STORE0 && cfg_off < `PSI_OFF_RSVD)
         st_next.mem[cfg_sid][5'(cfg_off - `PSI_OFF_STORE0)] = cfg_byte;

      // host orientation write overrides a same-cycle load
      wr_sid = sid_of(wr_pid);
      wr_ok = is_info(wr_pid) && wr_len == `PSI_LEN_WRITE && sensor_present[wr_sid];
      if (wr_start)
      begin
         if (wr_ok)
         begin
            st_next.mem[wr_sid][`PSI_OFF_MAT0 - `PSI_OFF_STORE0 +: `PSI_MAT_BYTES] = wr_matrix;
            st_next.wdone = 1'b1;
         end
         else
            st_next.werr = 1'b1;
      end

      remap_mat = st_reg.mem[remap_sid][`PSI_OFF_MAT0 - `PSI_OFF_STORE0 +: `PSI_MAT_BYTES];
      st_next.ex = column(raw_x, raw_y, raw_z, remap_mat, 0);
      st_next.ey = column(raw_x, raw_y, raw_z, remap_mat, 1);
      st_next.ez = column(raw_x, raw_y, raw_z, remap_mat, 2);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign rd_ready = (st_reg.fsm == PSI_IDLE);
   assign out_valid = st_reg.ovalid;
   assign out_byte = st_reg.obyte;
   assign out_last = st_reg.olast;
   assign wr_done = st_reg.wdone;
   assign wr_err = st_reg.werr;
   assign enu_x = st_reg.ex;
   assign enu_y = st_reg.ey;
   assign enu_z = st_reg.ez;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_pres_len;
      out_valid && st_reg.pid == `PSI_PID_PRESENT && st_reg.o_idx == `PSI_OFF_LEN |-> out_byte == 8'(`PSI_LEN_PRESENT);
   endproperty
   a_pres_len: assert property (p_pres_len) else $error("presence length wrong");

   property p_pres_bits;
      out_valid && st_reg.pid == `PSI_PID_PRESENT && st_reg.o_idx >= `PSI_HDR_BYTES
         |-> out_byte == st_reg.snap[8*(st_reg.o_idx - `PSI_HDR_BYTES) +: 8];
   endproperty
   a_pres_bits: assert property (p_pres_bits) else $error("presence bitmap byte wrong");

   property p_pres_count;
      rd_start && rd_ready && rd_pid == `PSI_PID_PRESENT |=> ##12 out_valid && out_last;
   endproperty
   a_pres_count: assert property (p_pres_count) else $error("presence response not 12 bytes");

   property p_info_id;
      out_valid && is_info(st_reg.pid) && st_reg.snap[sid_of(st_reg.pid)] && st_reg.o_idx == `PSI_OFF_ID
         |-> out_byte == 8'(st_reg.pid - `PSI_PID_INFO_FIRST);
   endproperty
   a_info_id: assert property (p_info_id) else $error("descriptor id byte wrong");

   property p_info_len;
      rd_start && rd_ready && is_info(rd_pid) |=> ##3 out_valid && out_byte == 8'(`PSI_LEN_INFO) ##21 out_last;
   endproperty
   a_info_len: assert property (p_info_len) else $error("descriptor length or size wrong");

   property p_absent;
      out_valid && is_info(st_reg.pid) && !st_reg.snap[sid_of(st_reg.pid)] && st_reg.o_idx >= `PSI_HDR_BYTES
         |-> out_byte == 8'h00;
   endproperty
   a_absent: assert property (p_absent) else $error("absent descriptor not zero");

   property p_rsvd;
      out_valid && is_info(st_reg.pid) && st_reg.o_idx == `PSI_OFF_RSVD |-> out_byte == 8'h00 && out_last;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");

   property p_addr_top;
      out_valid && is_info(st_reg.pid) && st_reg.o_idx == `PSI_OFF_ADDR &&
         desc[`PSI_OFF_FLAGS - `PSI_OFF_STORE0][`PSI_FLG_MST_HI:`PSI_FLG_MST_LO] == `PSI_MST_TWOWIRE_A
         |-> !out_byte[`PSI_ADDR_TOP];
   endproperty
   a_addr_top: assert property (p_addr_top) else $error("two-wire address top bit set");

   property p_wr_apply;
      wr_start && wr_ok |=> wr_done &&
         st_reg.mem[$past(wr_sid)][`PSI_OFF_MAT0 - `PSI_OFF_STORE0 +: `PSI_MAT_BYTES] == $past(wr_matrix);
   endproperty
   a_wr_apply: assert property (p_wr_apply) else $error("orientation write not applied");

   property p_wr_ignore;
      wr_start && !sensor_present[wr_sid] && !cfg_we |=> wr_err && !wr_done && $stable(st_reg.mem);
   endproperty
   a_wr_ignore: assert property (p_wr_ignore) else $error("write to absent sensor applied");

   property p_remap_id;
      coef(remap_mat, 0) == 4'sh1 && coef(remap_mat, 3) == 4'sh0 && coef(remap_mat, 6) == 4'sh0
         |=> enu_x == OW'($past(raw_x));
   endproperty
   a_remap_id: assert property (p_remap_id) else $error("east axis remap wrong");

endmodule

// ---- verif/psi_host.sv ----
/*
 host model: issues parameter reads and collects the response bytes.
 assumes the read port takes a request while rd_ready is high.
*/
`timescale 1ns/1ps
module psi_host (
   input wire logic clk_sys, // clock
   input wire logic rst_n, // reset, active low
   input wire logic go, // start a read
   input wire logic [15:0] pid, // parameter to read
   output logic rd_start, // read request
   output logic [15:0] rd_pid, // read parameter
   input wire logic rd_ready, // request may be taken
   input wire logic out_valid, // byte valid
   input wire logic [7:0] out_byte, // response byte
   input wire logic out_last, // final byte
   output logic [7:0] rsp [0:23], // collected bytes
   output int n, // bytes collected
   output logic done // response complete
);
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_start <= 1'b0;
         rd_pid <= 16'h0000;
         n <= 0;
         done <= 1'b0;
      end
      else
      begin
         if (go)
         begin
            rd_start <= 1'b1;
            rd_pid <= pid;
            n <= 0;
            done <= 1'b0;
         end
         else if (rd_start && rd_ready)
         begin
            // request dropped once taken; number no longer meaningful
            rd_start <= 1'b0;
            rd_pid <= ~rd_pid;
         end
         if (out_valid && n < 24)
         begin
            rsp[n] <= out_byte;
            n <= n + 1;
         end
         if (out_valid && out_last)
            done <= 1'b1;
      end
   end
endmodule

// ---- verif/test_psi_params.sv ----
/*
 testbench of the sensor information parameter block.
 assumes psi_host as read partner; writes and loads driven here.
*/
`timescale 1ns/1ps
`include "psi_consts.svh"
module test_psi_params;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [63:0] sensor_present = '0;
   logic cfg_we = 1'b0;
   logic [5:0] cfg_sid = '0;
   logic [4:0] cfg_off = '0;
   logic [7:0] cfg_byte = '0;
   logic rd_start, rd_ready, out_valid, out_last, wr_done, wr_err, go = 1'b0, done;
   logic [15:0] rd_pid, pid = '0, wr_pid = '0, wr_len = '0;
   logic [7:0] out_byte;
   logic wr_start = 1'b0;
   logic [39:0] wr_matrix = '0;
   logic [5:0] remap_sid = '0;
   logic signed [15:0] raw_x = '0, raw_y = '0, raw_z = '0;
   logic signed [20:0] enu_x, enu_y, enu_z;
   logic [7:0] rsp [0:23];
   logic [7:0] want [0:23];
   int n;
   int mismatches = 0;
   int samples_checked = 0;
   always #2 clk_sys = ~clk_sys;
   psi_params i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sensor_present(sensor_present), .cfg_we(cfg_we),
      .cfg_sid(cfg_sid), .cfg_off(cfg_off), .cfg_byte(cfg_byte), .rd_start(rd_start), .rd_pid(rd_pid),
      .rd_ready(rd_ready), .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last),
      .wr_start(wr_start), .wr_pid(wr_pid), .wr_len(wr_len), .wr_matrix(wr_matrix), .wr_done(wr_done),
      .wr_err(wr_err), .remap_sid(remap_sid), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
      .enu_x(enu_x), .enu_y(enu_y), .enu_z(enu_z));
   psi_host i_host (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .pid(pid), .rd_start(rd_start),
      .rd_pid(rd_pid), .rd_ready(rd_ready), .out_valid(out_valid), .out_byte(out_byte),
      .out_last(out_last), .rsp(rsp), .n(n), .done(done));
   task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_word(input string what, input logic [20:0] e, input logic [20:0] g);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // read one parameter, compare header and payload with want
   task automatic do_read(input logic [15:0] p, input int len);
      int i;
      want[0] = p[7:0];
      want[1] = p[15:8];
      want[2] = 8'(len);
      want[3] = 8'h00;
      @(posedge clk_sys);
      go <= 1'b1;
      pid <= p;
      @(posedge clk_sys);
      go <= 1'b0;
      #1;
      i = 0;
      while (done !== 1'b1 && i < 100)
      begin
         @(posedge clk_sys);
         i++;
      end
      #1;
      cmp_byte("response done", 8'h01, {7'h0, done});
      cmp_byte("response length", 8'(len + 4), 8'(n));
      for (i = 0; i < len + 4; i++)
         cmp_byte($sformatf("response byte %0d", i), want[i], rsp[i]);
   endtask
   task automatic cfg_load(input logic [4:0] o, input logic [7:0] v);
      @(posedge clk_sys);
      cfg_we <= 1'b1;
      cfg_sid <= 6'h01;
      cfg_off <= o;
      cfg_byte <= v;
      @(posedge clk_sys);
      cfg_we <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] p, input logic [15:0] l, input logic [39:0] mx, input logic ok);
      @(posedge clk_sys);
      wr_start <= 1'b1;
      wr_pid <= p;
      wr_len <= l;
      wr_matrix <= mx;
      @(posedge clk_sys);
      wr_start <= 1'b0;
      #1;
      cmp_byte("write applied", {7'h0, ok}, {7'h0, wr_done});
      cmp_byte("write ignored", {7'h0, !ok}, {7'h0, wr_err});
   endtask
   task automatic t_present();
      int ids [18] = '{1, 3, 5, 7, 9, 11, 13, 15, 17, 19, 32, 33, 34, 35, 36, 48, 49, 50};
      logic [7:0] bm [8] = '{8'haa, 8'haa, 8'h0a, 8'h00, 8'h1f, 8'h00, 8'h07, 8'h00};
      logic [63:0] m;
      m = '0;
      foreach (ids[k])
         m[ids[k]] = 1'b1;
      @(posedge clk_sys);
      sensor_present <= m;
      foreach (bm[k])
         want[4 + k] = bm[k];
      do_read(`PSI_PID_PRESENT, 8);
      $display("test present done");
   endtask
   task automatic t_desc();
      logic [7:0] v;
      for (int o = 5; o < 23; o++)
      begin
         v = (o == 10) ? 8'he5 : (o == 11) ? 8'hc8 : 8'(8'h30 + o);
         cfg_load(5'(o), v);
         want[o] = (o == 11) ? 8'h48 : v;
      end
      want[4] = 8'h01;
      want[23] = 8'h00;
      do_read(16'h0122, 20);
      cfg_load(5'h0a, 8'h03);
      want[10] = 8'h03;
      want[11] = 8'hc8;
      do_read(16'h0122, 20);
      cfg_load(5'h0a, 8'h08);
      want[10] = 8'h08;
      want[11] = 8'h48;
      do_read(16'h0122, 20);
      for (int i = 4; i < 24; i++)
         want[i] = 8'h00;
      do_read(`PSI_PID_INFO_FIRST, 20);
      do_read(16'h0161, 0);
      $display("test descriptor done");
   endtask
   task automatic t_orient();
      wr(16'h0122, 16'h0008, 40'h01_00_00_f0_10, 1'b1);
      wr(16'h0122, 16'h0007, 40'h11_11_11_11_11, 1'b0);
      wr(`PSI_PID_INFO_FIRST, 16'h0008, 40'h11_11_11_11_11, 1'b0);
      wr(16'h0161, 16'h0008, 40'h11_11_11_11_11, 1'b0);
      @(posedge clk_sys);
      remap_sid <= 6'h01;
      raw_x <= 16'sd3;
      raw_y <= 16'sd5;
      raw_z <= -16'sd7;
      repeat (2) @(posedge clk_sys);
      #1;
      cmp_word("east", -21'sd5, enu_x);
      cmp_word("north", 21'sd3, enu_y);
      cmp_word("up", -21'sd7, enu_z);
      for (int o = 5; o < 18; o++)
         want[o] = (o == 10) ? 8'h08 : (o == 11) ? 8'h48 : 8'(8'h30 + o);
      want[4] = 8'h01;
      want[18] = 8'h10;
      want[19] = 8'hf0;
      want[20] = 8'h00;
      want[21] = 8'h00;
      want[22] = 8'h01;
      do_read(16'h0122, 20);
      wr(16'h0122, 16'h0008, 40'h0f_00_0f_00_01, 1'b1);
      repeat (2) @(posedge clk_sys);
      #1;
      cmp_word("east flipped", 21'sd3, enu_x);
      cmp_word("north flipped", -21'sd5, enu_y);
      cmp_word("up flipped", 21'sd7, enu_z);
      $display("test orientation done");
   endtask
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      cmp_byte("ready after reset", 8'h01, {7'h0, rd_ready});
      cmp_byte("valid after reset", 8'h00, {7'h0, out_valid});
      t_present();
      t_desc();
      t_orient();
      stop_test();
   end
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      mismatches++;
      $display("mismatch watchdog expected finish seen timeout");
      stop_test();
   end
endmodule
